// *** core/dsl_flash_gen.sv ***
// Purpose: Flash waveform generator for the status indicators
// Assumes: i_tick is a one-cycle pulse every flicker period
// Notes: Phase a drives the error colour, phase b the run colour

`timescale 1ns/10ps
`default_nettype none

module dsl_flash_gen (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_tick,
    output dsl_pkg::dsl_wave_t o_wave
);
    import dsl_pkg::*;

    // Waves start where the counters start, so the two phases are opposite from reset on
    localparam dsl_wave_t WAVE_RST = '{blink_a: 1'b1, blink_b: 1'b0, single_a: 1'b1,
        single_b: 1'b0, double_a: 1'b1, flicker_a: 1'b0};

    logic [CNT_W-1:0] blink_cnt;
    logic [CNT_W-1:0] single_cnt;
    logic [CNT_W-1:0] double_cnt;
    logic flick;

    wire blink_wrap = (blink_cnt == BLINK_LEN - CNT_ONE);
    wire single_wrap = (single_cnt == SINGLE_LEN - CNT_ONE);
    wire double_wrap = (double_cnt == DOUBLE_LEN - CNT_ONE);
    wire [CNT_W-1:0] next_blink = blink_wrap ? '0 : blink_cnt + CNT_ONE;
    wire [CNT_W-1:0] next_single = single_wrap ? '0 : single_cnt + CNT_ONE;
    wire [CNT_W-1:0] next_double = double_wrap ? '0 : double_cnt + CNT_ONE;

    // Second flash sits one on-time after the first one ends
    wire double_on = (double_cnt < ON_TICKS) ||
        ((double_cnt >= (ON_TICKS << 1)) && (double_cnt < ON_TICKS * CNT_W'(3)));
    wire single_on_b = (single_cnt >= SINGLE_SHIFT) &&
        (single_cnt < SINGLE_SHIFT + ON_TICKS);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            blink_cnt <= '0;
            single_cnt <= '0;
            double_cnt <= '0;
            flick <= 1'b0;
        end else if (i_tick) begin
            blink_cnt <= next_blink;
            single_cnt <= next_single;
            double_cnt <= next_double;
            flick <= ~flick;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wave <= WAVE_RST;
        end else begin
            o_wave.blink_a <= (blink_cnt < ON_TICKS);
            o_wave.blink_b <= (blink_cnt >= ON_TICKS);
            o_wave.single_a <= (single_cnt < ON_TICKS);
            o_wave.single_b <= single_on_b;
            o_wave.double_a <= double_on;
            o_wave.flicker_a <= flick;
        end
    end

endmodule

`default_nettype wire

// *** core/dsl_led_top.sv ***
// Purpose: Drive ready/error LED and bi-colour network status LED
// Assumes: Slave state and error causes come from the state machine
// Notes: Registers on Avalon-MM, one wait state per access

`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Green ready LED lights once power-on initialisation has finished.
// - Green ready LED goes dark whenever any error is present.
// - Red ready LED lights on any error or when the fault output is driven low.
// - Status LED merges green run and red error patterns, run 180 degrees shifted.
// - When both colours are wanted at once the status LED shows red only.
// - Run pattern is off in the INIT state.
// - Run pattern blinks in the PRE-OPERATIONAL state.
// - Run pattern single-flashes in the SAFE-OPERATIONAL state.
// - Run pattern is steady on in the OPERATIONAL state.
// - Error pattern is steady on for a critical or controller failure.
// - Error pattern double-flashes on a process data watchdog timeout.
// - Error pattern single-flashes on a local error flagged in AL status.
// - Error pattern flickers when INIT is reached with the error flag set.
// - Error pattern is off when communication works with no error.
module dsl_led_top #(
    parameter int TICK_CYCLES = dsl_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [dsl_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_init_done,
    input wire logic i_drive_error,
    input wire dsl_pkg::dsl_slave_state_t i_slave_state,
    input wire dsl_pkg::dsl_net_err_t i_net_err,
    output logic o_ready_green,
    output logic o_ready_red,
    output logic o_net_green,
    output logic o_net_red,
    output logic o_irq
);
    import dsl_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES);

    ////////////////////////////////////////////////////////////////////////
    // Flash time base

    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    dsl_wave_t wave;

    wire tick_wrap = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick_cnt <= tick_wrap ? '0 : tick_cnt + TICK_W'(1);
            tick <= tick_wrap;
        end
    end

    dsl_flash_gen u_flash (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_tick(tick),
        .o_wave(wave)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register bus slave

    logic served;
    logic fault_out;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;

    wire bus_req = i_avs_read | i_avs_write;
    wire bus_done = bus_req & served;
    wire wr_ctrl = bus_done & i_avs_write & (i_avs_address == REG_CTRL);
    wire wr_istat = bus_done & i_avs_write & (i_avs_address == REG_IRQ_STAT);
    wire wr_imask = bus_done & i_avs_write & (i_avs_address == REG_IRQ_MASK);

    // One wait state gives the read mux a full cycle
    assign o_avs_waitrequest = bus_req & ~served;

    ////////////////////////////////////////////////////////////////////////
    // Indicator decode

    logic init_seen;
    logic [IRQ_W-1:0] evt_prev;
    dsl_slave_state_t state_prev;
    dsl_err_pat_t err_sel;

    wire boot_err = i_net_err.al_error & (i_slave_state == SLV_INIT);
    wire net_err_any = |i_net_err;
    wire drive_err_any = i_drive_error | net_err_any;

    always_comb begin
        if (i_net_err.critical) begin
            err_sel = ERR_ON;
        end else if (i_net_err.watchdog) begin
            err_sel = ERR_DOUBLE;
        end else if (boot_err) begin
            err_sel = ERR_FLICKER;
        end else if (i_net_err.al_error) begin
            err_sel = ERR_SINGLE;
        end else if (i_net_err.config_err) begin
            err_sel = ERR_BLINK;
        end else begin
            err_sel = ERR_OFF;
        end
    end

    logic err_lit;
    logic run_lit;

    always_comb begin
        case (err_sel)
            ERR_ON: err_lit = 1'b1;
            ERR_DOUBLE: err_lit = wave.double_a;
            ERR_FLICKER: err_lit = wave.flicker_a;
            ERR_SINGLE: err_lit = wave.single_a;
            ERR_BLINK: err_lit = wave.blink_a;
            default: err_lit = 1'b0;
        endcase
    end

    // Run colour uses phase b so it sits opposite the error colour
    always_comb begin
        case (i_slave_state)
            SLV_PREOP: run_lit = wave.blink_b;
            SLV_SAFEOP: run_lit = wave.single_b;
            SLV_OP: run_lit = 1'b1;
            default: run_lit = 1'b0;
        endcase
    end

    wire next_net_red = err_lit;
    wire next_net_green = run_lit & ~err_lit;
    wire next_ready_green = init_seen & ~drive_err_any;
    wire next_ready_red = drive_err_any | ~fault_out;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_net_red <= 1'b0;
            o_net_green <= 1'b0;
            o_ready_green <= 1'b0;
            o_ready_red <= 1'b0;
            init_seen <= 1'b0;
        end else begin
            o_net_red <= next_net_red;
            o_net_green <= next_net_green;
            o_ready_green <= next_ready_green;
            o_ready_red <= next_ready_red;
            init_seen <= init_seen | i_init_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events

    wire [IRQ_W-1:0] evt_level = {i_net_err.watchdog, init_seen, 1'b0, drive_err_any};
    wire state_chg = (i_slave_state != state_prev);
    wire [IRQ_W-1:0] evt_rise = (evt_level & ~evt_prev) | (IRQ_W'(state_chg) << IRQ_STATE);
    wire [IRQ_W-1:0] clr_mask = wr_istat ? i_avs_writedata[IRQ_W-1:0] : '0;
    // Set wins over a write-one-to-clear in the same cycle
    wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~clr_mask) | evt_rise;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            evt_prev <= '0;
            state_prev <= SLV_INIT;
            irq_stat <= IRQ_RST;
        end else begin
            evt_prev <= evt_level;
            state_prev <= i_slave_state;
            irq_stat <= next_irq_stat;
        end
    end

    assign o_irq = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // Register storage and read mux

    logic [31:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[ST_READY_GREEN] = o_ready_green;
        status_word[ST_READY_RED] = o_ready_red;
        status_word[ST_NET_GREEN] = o_net_green;
        status_word[ST_NET_RED] = o_net_red;
        status_word[ST_SLAVE_LSB +: 4] = i_slave_state;
        status_word[ST_ERRPAT_LSB +: 6] = err_sel;
    end

    logic [31:0] rd_mux;

    always_comb begin
        case (i_avs_address)
            REG_CTRL: rd_mux = {31'h0, fault_out};
            REG_STATUS: rd_mux = status_word;
            REG_IRQ_STAT: rd_mux = {28'h0, irq_stat};
            REG_IRQ_MASK: rd_mux = {28'h0, irq_mask};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            served <= 1'b0;
            o_avs_readdata <= 32'h0;
        end else begin
            served <= bus_req & ~served;
            if (i_avs_read & ~served) begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fault_out <= CTRL_FAULT_OUT_RST;
            irq_mask <= IRQ_RST;
        end else begin
            if (wr_ctrl) begin
                fault_out <= i_avs_writedata[CTRL_FAULT_OUT];
            end
            if (wr_imask) begin
                irq_mask <= i_avs_writedata[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    ready_green_on_a: assert property (
        (init_seen && !drive_err_any) |=> o_ready_green)
        else $error("ready green not lit after init");

    ready_green_off_a: assert property (
        drive_err_any |=> !o_ready_green)
        else $error("ready green lit during error");

    ready_red_on_a: assert property (
        (drive_err_any || (wr_ctrl && !i_avs_writedata[CTRL_FAULT_OUT]))
        |=> ##[0:1] o_ready_red)
        else $error("ready red not lit on error or fault low");

    phase_opposite_a: assert property (
        wave.blink_a != wave.blink_b)
        else $error("run blink not opposite error blink");

    red_wins_a: assert property (
        !(o_net_green && o_net_red))
        else $error("status led shows both colours");

    run_init_off_a: assert property (
        (i_slave_state == SLV_INIT) |=> !o_net_green)
        else $error("run lit in init");

    run_preop_blink_a: assert property (
        (i_slave_state == SLV_PREOP && !net_err_any) |=> o_net_green == $past(wave.blink_b))
        else $error("run not blinking in preop");

    run_safeop_flash_a: assert property (
        (i_slave_state == SLV_SAFEOP && !net_err_any)
        |=> o_net_green == $past(wave.single_b))
        else $error("run not single flashing in safeop");

    run_op_on_a: assert property (
        (i_slave_state == SLV_OP && !net_err_any) |=> o_net_green)
        else $error("run not steady in op");

    err_critical_on_a: assert property (
        i_net_err.critical |=> o_net_red)
        else $error("error not steady on critical failure");

    err_watchdog_dbl_a: assert property (
        (i_net_err.watchdog && !i_net_err.critical) |=> o_net_red == $past(wave.double_a))
        else $error("error not double flashing on watchdog");

    err_local_flash_a: assert property (
        (i_net_err == 4'h2 && i_slave_state != SLV_INIT) |=> o_net_red == $past(wave.single_a))
        else $error("error not single flashing on local error");

    err_boot_flick_a: assert property (
        (i_net_err == 4'h2 && i_slave_state == SLV_INIT)
        |=> o_net_red == $past(wave.flicker_a))
        else $error("error not flickering on boot error");

    err_none_off_a: assert property (
        !net_err_any |=> !o_net_red)
        else $error("error lit with no error");

    err_config_blink_a: assert property (
        (i_net_err == 4'h1) |=> o_net_red == $past(wave.blink_a))
        else $error("error not blinking on config error");

    flicker_toggle_a: assert property (
        tick |=> ##1 (wave.flicker_a != $past(wave.flicker_a)))
        else $error("flicker did not toggle on tick");

    irq_level_a: assert property (
        (|(irq_stat & irq_mask)) |-> o_irq)
        else $error("interrupt low with unmasked status");

    irq_set_wins_a: assert property (
        (|evt_rise) |=> ((irq_stat & $past(evt_rise)) == $past(evt_rise)))
        else $error("status event lost against a clear");

    fault_low_red_a: assert property (
        !fault_out |=> o_ready_red)
        else $error("ready red dark while fault output low");

    one_wait_state_a: assert property (
        (bus_req && !served) |=> !o_avs_waitrequest)
        else $error("more than one wait state");

    readdata_hold_a: assert property (
        !(i_avs_read && !served) |=> $stable(o_avs_readdata))
        else $error("read data changed without a read");

    preop_cover_c: cover property (
        i_slave_state == SLV_PREOP && o_net_green);
    op_error_cover_c: cover property (
        i_slave_state == SLV_OP && i_net_err.watchdog ##1 o_net_red);
    boot_cover_c: cover property (boot_err && !i_net_err.critical ##1 o_net_red);
    irq_cover_c: cover property (o_irq ##1 wr_istat);

endmodule

`default_nettype wire

// *** inc/dsl_pkg.sv ***
// Purpose: Shared constants and types for the drive status LED block
// Assumes: 25 MHz system clock, 50 ms flash time base
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave

package dsl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int FLICKER_MS = 50;
    localparam int BLINK_MS = 200;
    localparam int FLASH_OFF_MS = 1000;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * FLICKER_MS;

    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] ON_TICKS = CNT_W'(BLINK_MS / FLICKER_MS);
    localparam logic [CNT_W-1:0] OFF_TICKS = CNT_W'(FLASH_OFF_MS / FLICKER_MS);
    localparam logic [CNT_W-1:0] BLINK_LEN = CNT_W'(2 * BLINK_MS / FLICKER_MS);
    localparam logic [CNT_W-1:0] SINGLE_LEN = ON_TICKS + OFF_TICKS;
    localparam logic [CNT_W-1:0] DOUBLE_LEN = CNT_W'(3 * BLINK_MS / FLICKER_MS) + OFF_TICKS;
    localparam logic [CNT_W-1:0] SINGLE_SHIFT = SINGLE_LEN >> 1;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h8;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hC;

    localparam int CTRL_FAULT_OUT = 0;
    localparam logic CTRL_FAULT_OUT_RST = 1'b1;

    localparam int ST_READY_GREEN = 0;
    localparam int ST_READY_RED = 1;
    localparam int ST_NET_GREEN = 2;
    localparam int ST_NET_RED = 3;
    localparam int ST_SLAVE_LSB = 4;
    localparam int ST_ERRPAT_LSB = 8;

    localparam int IRQ_W = 4;
    localparam int IRQ_ERR = 0;
    localparam int IRQ_STATE = 1;
    localparam int IRQ_INIT = 2;
    localparam int IRQ_WDOG = 3;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [3:0] {
        SLV_INIT = 4'h1,
        SLV_PREOP = 4'h2,
        SLV_SAFEOP = 4'h4,
        SLV_OP = 4'h8
    } dsl_slave_state_t;

    typedef enum logic [5:0] {
        ERR_OFF = 6'h01,
        ERR_BLINK = 6'h02,
        ERR_SINGLE = 6'h04,
        ERR_DOUBLE = 6'h08,
        ERR_FLICKER = 6'h10,
        ERR_ON = 6'h20
    } dsl_err_pat_t;

    typedef struct packed {
        logic critical;
        logic watchdog;
        logic al_error;
        logic config_err;
    } dsl_net_err_t;

    typedef struct packed {
        logic blink_a;
        logic blink_b;
        logic single_a;
        logic single_b;
        logic double_a;
        logic flicker_a;
    } dsl_wave_t;

endpackage

// *** test/dsl_led_top_bench.sv ***
// Purpose: Self-checking bench for the status LED block
// Assumes: Flash tick shortened to 4 clocks, so one tick is 4 cycles
// Notes: Window of 384 cycles is a whole number of every pattern period

`timescale 1ns/10ps
`default_nettype none

module dsl_led_top_bench;
    import dsl_pkg::*;

    localparam int SETTLE = 128;
    localparam int WIN = 384;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_wdata = 32'h0;
    logic [31:0] avs_rdata;
    logic avs_wait;
    logic init_done = 1'b0;
    logic drive_error = 1'b0;
    dsl_slave_state_t slave_state = SLV_INIT;
    dsl_net_err_t net_err = 4'h0;
    logic ready_green, ready_red, net_green, net_red, irq;
    logic view_clr = 1'b0;
    int g_hi, g_on, g_off, r_hi, r_on, r_off;
    int error_cnt = 0;
    int num_checks = 0;
    int both_cnt = 0;

    always #20 clk = ~clk;

    dsl_led_top #(.TICK_CYCLES(4)) i_dut (
        .i_clk(clk), .i_arst_n(arst_n),
        .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_writedata(avs_wdata), .o_avs_readdata(avs_rdata),
        .o_avs_waitrequest(avs_wait), .i_init_done(init_done),
        .i_drive_error(drive_error), .i_slave_state(slave_state), .i_net_err(net_err),
        .o_ready_green(ready_green), .o_ready_red(ready_red),
        .o_net_green(net_green), .o_net_red(net_red), .o_irq(irq)
    );

    dsl_led_viewer i_green (.i_clk(clk), .i_clr(view_clr), .i_led(net_green),
        .o_hi_cnt(g_hi), .o_on_len(g_on), .o_off_len(g_off));
    dsl_led_viewer i_red (.i_clk(clk), .i_clr(view_clr), .i_led(net_red),
        .o_hi_cnt(r_hi), .o_on_len(r_on), .o_off_len(r_off));

    always @(posedge clk) begin
        if (net_green === 1'b1 && net_red === 1'b1) both_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Request is held until waitrequest is seen low at a rising edge
    task automatic av_xfer(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= a;
        avs_wdata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_wait !== 1'b0);
        rd = avs_rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic apply(input dsl_slave_state_t st, input logic [3:0] err);
        @(posedge clk);
        slave_state <= st;
        net_err <= dsl_net_err_t'(err);
        repeat (SETTLE) @(posedge clk);
        view_clr <= 1'b1;
        @(posedge clk);
        view_clr <= 1'b0;
        step(WIN);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        logic [31:0] d;
        chk("green_before_init", 32'(ready_green), 32'h0);
        chk("irq_reset", 32'(irq), 32'h0);
        av_xfer(1'b0, REG_CTRL, 32'h0, d);
        chk("ctrl_reset", d, 32'h1);
        av_xfer(1'b0, REG_IRQ_MASK, 32'h0, d);
        chk("mask_reset", d, 32'h0);
        av_xfer(1'b1, 4'h2, 32'hFFFFFFFF, d);
        av_xfer(1'b0, 4'h2, 32'h0, d);
        chk("unmapped", d, 32'h0);
    endtask

    task automatic test_ready_led();
        logic [31:0] d;
        @(posedge clk);
        init_done <= 1'b1;
        step(3);
        chk("green_init", 32'(ready_green), 32'h1);
        chk("red_init", 32'(ready_red), 32'h0);
        @(posedge clk);
        drive_error <= 1'b1;
        step(3);
        chk("green_drv_err", 32'(ready_green), 32'h0);
        chk("red_drv_err", 32'(ready_red), 32'h1);
        @(posedge clk);
        drive_error <= 1'b0;
        net_err <= dsl_net_err_t'(4'h8);
        step(3);
        chk("green_net_err", 32'(ready_green), 32'h0);
        chk("red_net_err", 32'(ready_red), 32'h1);
        @(posedge clk);
        net_err <= dsl_net_err_t'(4'h0);
        step(3);
        chk("green_back", 32'(ready_green), 32'h1);
        av_xfer(1'b1, REG_CTRL, 32'h0, d);
        step(2);
        chk("red_fault_out", 32'(ready_red), 32'h1);
        av_xfer(1'b0, REG_CTRL, 32'h0, d);
        chk("ctrl_rw", d, 32'h0);
        av_xfer(1'b1, REG_CTRL, 32'h1, d);
        step(2);
        chk("red_fault_off", 32'(ready_red), 32'h0);
    endtask

    task automatic test_irq();
        logic [31:0] d;
        av_xfer(1'b1, REG_IRQ_MASK, 32'h0, d);
        av_xfer(1'b1, REG_IRQ_STAT, 32'hF, d);
        av_xfer(1'b0, REG_IRQ_STAT, 32'h0, d);
        chk("irq_stat_clear", d, 32'h0);
        @(posedge clk);
        drive_error <= 1'b1;
        step(3);
        chk("irq_masked", 32'(irq), 32'h0);
        av_xfer(1'b0, REG_IRQ_STAT, 32'h0, d);
        chk("irq_err_bit", 32'(d[IRQ_ERR]), 32'h1);
        av_xfer(1'b1, REG_IRQ_MASK, 32'h1, d);
        step(1);
        chk("irq_raised", 32'(irq), 32'h1);
        av_xfer(1'b1, REG_IRQ_STAT, 32'h1, d);
        step(1);
        chk("irq_w1c", 32'(irq), 32'h0);
        @(posedge clk);
        drive_error <= 1'b0;
    endtask

    task automatic test_run_pattern();
        apply(SLV_INIT, 4'h0);
        chk("run_init_hi", g_hi, 32'h0);
        apply(SLV_PREOP, 4'h0);
        chk("run_preop_hi", g_hi, 32'hC0);
        chk("run_preop_on", g_on, 32'h10);
        chk("run_preop_off", g_off, 32'h10);
        apply(SLV_SAFEOP, 4'h0);
        chk("run_safeop_hi", g_hi, 32'h40);
        chk("run_safeop_on", g_on, 32'h10);
        chk("run_safeop_off", g_off, 32'h50);
        apply(SLV_OP, 4'h0);
        chk("run_op_hi", g_hi, 32'h180);
        chk("run_op_red", r_hi, 32'h0);
    endtask

    task automatic err_case(input dsl_slave_state_t st, input logic [3:0] err,
            input dsl_err_pat_t pat, input logic [31:0] hi, input logic [31:0] on);
        logic [31:0] d;
        apply(st, err);
        chk("err_hi", r_hi, hi);
        if (on !== 32'h0) chk("err_on_len", r_on, on);
        av_xfer(1'b0, REG_STATUS, 32'h0, d);
        chk("err_pattern", 32'(d[13:8]), 32'(pat));
        chk("slave_state", 32'(d[7:4]), 32'(st));
    endtask

    task automatic test_err_pattern();
        err_case(SLV_INIT, 4'h8, ERR_ON, 32'h180, 32'h0);
        err_case(SLV_INIT, 4'hC, ERR_ON, 32'h180, 32'h0);
        err_case(SLV_INIT, 4'h4, ERR_DOUBLE, 32'h60, 32'h10);
        err_case(SLV_SAFEOP, 4'h2, ERR_SINGLE, 32'h40, 32'h10);
        err_case(SLV_INIT, 4'h2, ERR_FLICKER, 32'hC0, 32'h4);
        err_case(SLV_INIT, 4'h1, ERR_BLINK, 32'hC0, 32'h10);
        err_case(SLV_OP, 4'h0, ERR_OFF, 32'h0, 32'h0);
    endtask

    // Both colours blinking: in phase, red would hide green entirely
    task automatic test_merge();
        apply(SLV_PREOP, 4'h1);
        chk("merge_red_hi", r_hi, 32'hC0);
        chk("merge_green_hi", g_hi, 32'hC0);
        apply(SLV_SAFEOP, 4'h2);
        chk("merge_red_flash", r_hi, 32'h40);
        chk("merge_green_flash", g_hi, 32'h40);
        apply(SLV_OP, 4'h8);
        chk("red_wins_green", g_hi, 32'h0);
        chk("red_wins_red", r_hi, 32'h180);
        chk("both_lit", both_cnt, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        step(1);
        test_reset();
        test_ready_led();
        test_irq();
        test_run_pattern();
        test_err_pattern();
        test_merge();
        results();
    end

    // Roughly 7300 cycles are needed; give more than twice that
    initial begin
        #(40 * 20000);
        error_cnt++;
        results();
    end
endmodule

`default_nettype wire

// *** test/dsl_led_viewer.sv ***
// Purpose: Operator's eye on one status LED: lit time and run lengths
// Assumes: LED level is looked at once per system clock
// Notes: A run still open at the clear is counted from the clear

`timescale 1ns/10ps
`default_nettype none

module dsl_led_viewer (
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic i_led,
    output var int o_hi_cnt,
    output var int o_on_len,
    output var int o_off_len
);
    int run;
    logic prev;

    // Only the last complete run is kept, so a window of several periods hides the partial one
    always @(posedge i_clk) begin
        if (i_clr) begin
            run <= 0;
            o_hi_cnt <= 0;
            o_on_len <= 0;
            o_off_len <= 0;
            prev <= i_led;
        end else begin
            if (i_led === 1'b1) o_hi_cnt <= o_hi_cnt + 1;
            if (i_led !== prev) begin
                if (prev === 1'b1) o_on_len <= run;
                else o_off_len <= run;
                run <= 1;
            end else begin
                run <= run + 1;
            end
            prev <= i_led;
        end
    end
endmodule

`default_nettype wire
